/* core/aic_pkg.sv */
package aic_pkg;
  // Link framing
  localparam logic [6:0] DEV_ADDR = 7'h6c;
  localparam int DIR_POS = 0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [2:0] N_STAT = 3'h4;
  // Reset values of the control bytes
  localparam logic [7:0] CB1_RST = 8'h00;
  localparam logic [7:0] CB2_RST = 8'h00;
  // Control byte one fields
  localparam int CB1_DIAG_TIMING = 7;
  localparam int CB1_DIAG_EN = 6;
  localparam int CB1_OFFSET_EN = 5;
  localparam int CB1_FRONT_GAIN = 4;
  localparam int CB1_REAR_GAIN = 3;
  localparam int CB1_FRONT_UNMUTE = 2;
  localparam int CB1_REAR_UNMUTE = 1;
  localparam int CB1_CLIP_THR = 0;
  // Control byte two fields
  localparam int CB2_CUR_THR = 7;
  localparam int CB2_FAST_MUTE = 6;
  localparam int CB2_CLIP_PIN = 5;
  localparam int CB2_STBY_OFF = 4;
  localparam int CB2_LINE_DIAG = 3;
  localparam int CB2_CUR_EN = 2;
  localparam int CB2_FRONT_LOWIQ = 1;
  localparam int CB2_REAR_LOWIQ = 0;
  // Status byte fields
  localparam int ST_HI = 7;
  localparam int ST_LO = 6;
  localparam int ST_CUR = 5;
  localparam int ST_PERM = 4;
  localparam int ST_SLOAD = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_SVCC = 1;
  localparam int ST_SGND = 0;
  // Fault sense inputs per channel
  localparam int NCH = 4;
  localparam int FLT_W = 7;
  localparam int FI_SGND = 0;
  localparam int FI_SVCC = 1;
  localparam int FI_SLOAD = 2;
  localparam int FI_OPEN = 3;
  localparam int FI_OFFS = 4;
  localparam int FI_PERM = 5;
  localparam int FI_CUR = 6;
  localparam int FS_W = 2 + NCH * FLT_W;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_READ = 4'b1000
  } aic_state_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic [FS_W-1:0] flt_s1;
    logic [FS_W-1:0] flt_s2;
    aic_state_t state;
    logic [3:0] bcnt;
    logic [2:0] idx;
    logic rd;
    logic ack_pend;
    logic oe;
    logic mnack;
    logic start_p;
    logic [7:0] stage;
    logic [7:0] cb1;
    logic [7:0] cb2;
    logic [NCH-1:0][7:0] tx;
    logic [NCH-1:0][2:0] held;
    logic [NCH-1:0] once;
  } aic_sys_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [6:0] sh;
    logic [7:0] rx;
    logic tgl;
  } aic_lnk_t;
endpackage : aic_pkg

/* core/aic_ctrl_port.sv */
`timescale 1ns/1ps
module aic_link_rx (
  // Link
  input wire logic scl_clk,
  input wire logic clr,
  input wire logic sda_in,
  // Received byte
  output logic [7:0] rx_byte,
  output logic rx_tgl
);
  aic_pkg::aic_lnk_t l_ff;
  aic_pkg::aic_lnk_t nxt_l;

  always_comb begin
    nxt_l = l_ff;
    if (l_ff.cnt == aic_pkg::BIT_ACK) begin
      nxt_l.cnt = 4'h0;
    end else begin
      nxt_l.cnt = l_ff.cnt + 4'h1;
    end
    if (l_ff.cnt < aic_pkg::BIT_ACK) begin
      nxt_l.sh = {l_ff.sh[5:0], sda_in};
    end
    if (l_ff.cnt == aic_pkg::BIT_LAST) begin
      nxt_l.rx = {l_ff.sh, sda_in};
      nxt_l.tgl = ~l_ff.tgl;
    end
  end

  // Cleared by each start condition
  always_ff @(posedge scl_clk or posedge clr) begin
    if (clr) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end

  assign rx_byte = l_ff.rx;
  assign rx_tgl = l_ff.tgl;
endmodule : aic_link_rx

module aic_ctrl_port (
  // System
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Analog fault sense
  input wire logic thermal_warn,
  input wire logic diag_done,
  input wire logic [aic_pkg::NCH-1:0][aic_pkg::FLT_W-1:0] chan_flt,
  // Control byte one fields
  output logic diag_timing_normal,
  output logic diag_cycle_en,
  output logic offset_det_en,
  output logic front_gain_low,
  output logic rear_gain_low,
  output logic front_unmute,
  output logic rear_unmute,
  output logic clip_thr_high,
  // Control byte two fields
  output logic cur_thr_low,
  output logic fast_mute,
  output logic clip_pin_offset,
  output logic standby_off,
  output logic line_drv_diag,
  output logic cur_det_en,
  output logic front_low_iq,
  output logic rear_low_iq
);
  aic_pkg::aic_sys_t s;
  aic_pkg::aic_sys_t n;
  logic [7:0] lnk_byte;
  logic lnk_tgl;
  logic lnk_clr;
  logic rise_c;
  logic fall_c;
  logic start_c;
  logic stop_c;
  logic noss_c;
  logic evt_c;
  logic match_c;
  logic bit_c;
  logic [3:0] nb;
  logic [aic_pkg::NCH-1:0][aic_pkg::FLT_W-1:0] f_c;
  logic [aic_pkg::NCH-1:0][7:0] stat_c;
  logic [aic_pkg::NCH-1:0] combo_c;

  assign lnk_clr = s.start_p | ~rst_n;

  aic_link_rx u_rx (
    .scl_clk(scl_clk),
    .clr(lnk_clr),
    .sda_in(sda_in),
    .rx_byte(lnk_byte),
    .rx_tgl(lnk_tgl)
  );

  // Edges and conditions on the synced pins
  assign rise_c = s.scl_s2 & ~s.scl_s3;
  assign fall_c = ~s.scl_s2 & s.scl_s3;
  assign start_c = s.scl_s2 & s.scl_s3 & s.sda_s3 & ~s.sda_s2;
  assign stop_c = s.scl_s2 & s.scl_s3 & ~s.sda_s3 & s.sda_s2;
  assign noss_c = ~start_c & ~stop_c;
  assign evt_c = s.tgl_s2 ^ s.tgl_s3;
  assign match_c = lnk_byte[7:1] == aic_pkg::DEV_ADDR;
  assign f_c = s.flt_s2[aic_pkg::NCH*aic_pkg::FLT_W-1:0];
  assign bit_c = s.tx[s.idx[1:0]][3'(4'h6 - s.bcnt)];

  // Status bytes from live and held faults
  always_comb begin
    for (int c = 0; c < aic_pkg::NCH; c++) begin
      combo_c[c] = f_c[c][aic_pkg::FI_PERM] & f_c[c][aic_pkg::FI_SVCC] & f_c[c][aic_pkg::FI_SGND];
      stat_c[c][aic_pkg::ST_CUR] = f_c[c][aic_pkg::FI_CUR]
        & s.cb2[aic_pkg::CB2_CUR_EN];
      stat_c[c][aic_pkg::ST_PERM] = f_c[c][aic_pkg::FI_PERM];
      stat_c[c][aic_pkg::ST_SLOAD] = f_c[c][aic_pkg::FI_SLOAD]
        | s.held[c][aic_pkg::FI_SLOAD];
      stat_c[c][aic_pkg::ST_OPEN] = f_c[c][aic_pkg::FI_PERM]
        ? (s.cb1[aic_pkg::CB1_OFFSET_EN] & f_c[c][aic_pkg::FI_OFFS])
        : f_c[c][aic_pkg::FI_OPEN];
      stat_c[c][aic_pkg::ST_SVCC] = (f_c[c][aic_pkg::FI_SVCC]
        | s.held[c][aic_pkg::FI_SVCC]) & ~(combo_c[c] & s.once[c]);
      stat_c[c][aic_pkg::ST_SGND] = (f_c[c][aic_pkg::FI_SGND]
        | s.held[c][aic_pkg::FI_SGND]) & ~(combo_c[c] & s.once[c]);
    end
    stat_c[3][aic_pkg::ST_HI:aic_pkg::ST_LO] = 2'b00;
    stat_c[0][aic_pkg::ST_HI] = s.flt_s2[aic_pkg::FS_W-1];
    stat_c[0][aic_pkg::ST_LO] = s.flt_s2[aic_pkg::FS_W-2] & s.cb1[aic_pkg::CB1_DIAG_EN];
    stat_c[1][aic_pkg::ST_HI] = s.cb1[aic_pkg::CB1_OFFSET_EN];
    stat_c[1][aic_pkg::ST_LO] = s.cb2[aic_pkg::CB2_CUR_EN];
    stat_c[2][aic_pkg::ST_HI] = s.cb2[aic_pkg::CB2_STBY_OFF];
    stat_c[2][aic_pkg::ST_LO] = s.cb1[aic_pkg::CB1_DIAG_EN];
  end

  always_comb begin
    nb = 4'h0;
    n = s;
    n.start_p = 1'b0;
    // Synchronisers
    {n.scl_s3, n.scl_s2, n.scl_s1} = {s.scl_s2, s.scl_s1, scl_clk};
    {n.sda_s3, n.sda_s2, n.sda_s1} = {s.sda_s2, s.sda_s1, sda_in};
    {n.tgl_s3, n.tgl_s2, n.tgl_s1} = {s.tgl_s2, s.tgl_s1, lnk_tgl};
    n.flt_s1 = {thermal_warn, diag_done, chan_flt};
    n.flt_s2 = s.flt_s1;
    // Short faults held until a read reports them
    for (int c = 0; c < aic_pkg::NCH; c++) begin
      if (f_c[c][aic_pkg::FI_PERM]) begin
        n.held[c] = s.held[c] | f_c[c][2:0];
      end
      if (!combo_c[c]) begin
        n.once[c] = 1'b0;
      end
    end
    if (start_c || s.start_p) begin
      n.tgl_s1 = 1'b0;
      n.tgl_s2 = 1'b0;
      n.tgl_s3 = 1'b0;
    end
    if (start_c) begin
      n.state = aic_pkg::ST_ADDR;
      n.bcnt = aic_pkg::BIT_ACK;
      n.idx = 3'h0;
      n.ack_pend = 1'b0;
      n.oe = 1'b0;
      n.mnack = 1'b0;
      n.start_p = 1'b1;
    end else if (stop_c) begin
      n.state = aic_pkg::ST_IDLE;
      n.ack_pend = 1'b0;
      n.oe = 1'b0;
    end else begin
      // Byte arrived from the link
      if (evt_c) begin
        unique case (s.state)
          aic_pkg::ST_ADDR: begin
            if (match_c) begin
              n.ack_pend = 1'b1;
              n.rd = lnk_byte[aic_pkg::DIR_POS];
              if (lnk_byte[aic_pkg::DIR_POS]) begin
                n.tx = stat_c;
                for (int c = 0; c < aic_pkg::NCH; c++) begin
                  if (combo_c[c]) begin
                    n.once[c] = 1'b1;
                  end
                  n.held[c] = f_c[c][aic_pkg::FI_PERM] ? f_c[c][2:0] : 3'h0;
                end
              end
            end else begin
              n.state = aic_pkg::ST_IDLE;
            end
          end
          aic_pkg::ST_WRITE: begin
            if (s.idx == 3'h0) begin
              n.stage = lnk_byte;
              n.ack_pend = 1'b1;
              n.idx = 3'h1;
            end else if (s.idx == 3'h1) begin
              n.cb1 = s.stage;
              n.cb2 = lnk_byte;
              n.ack_pend = 1'b1;
              n.idx = 3'h2;
            end
          end
          aic_pkg::ST_IDLE, aic_pkg::ST_READ: begin
          end
        endcase
      end
      // Host acknowledge after each status byte
      if (rise_c && s.state == aic_pkg::ST_READ && s.bcnt == aic_pkg::BIT_ACK) begin
        n.mnack = s.sda_s2;
      end
      // Drive changes only while the clock is low
      if (fall_c) begin
        nb = (s.bcnt == aic_pkg::BIT_ACK) ? 4'h0 : s.bcnt + 4'h1;
        n.bcnt = nb;
        if (nb == aic_pkg::BIT_ACK) begin
          n.oe = (s.state != aic_pkg::ST_READ) & n.ack_pend;
        end else if (nb == 4'h0) begin
          n.ack_pend = 1'b0;
          n.oe = 1'b0;
          if (s.state == aic_pkg::ST_ADDR && s.ack_pend) begin
            n.state = s.rd ? aic_pkg::ST_READ : aic_pkg::ST_WRITE;
            n.oe = s.rd & ~s.tx[0][7];
          end else if (s.state == aic_pkg::ST_READ) begin
            if (s.mnack) begin
              n.state = aic_pkg::ST_IDLE;
            end else if (s.idx < aic_pkg::N_STAT) begin
              n.idx = s.idx + 3'h1;
              n.oe = (n.idx < aic_pkg::N_STAT) & ~s.tx[n.idx[1:0]][7];
            end
          end
        end else if (s.state == aic_pkg::ST_READ) begin
          n.oe = (s.idx < aic_pkg::N_STAT) & ~bit_c;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
      {s.scl_s1, s.scl_s2, s.scl_s3, s.sda_s1, s.sda_s2, s.sda_s3} <= '1;
      s.state <= aic_pkg::ST_IDLE;
      s.bcnt <= aic_pkg::BIT_ACK;
      s.cb1 <= aic_pkg::CB1_RST;
      s.cb2 <= aic_pkg::CB2_RST;
    end else begin
      s <= n;
    end
  end

  // Open-drain data line
  assign sda_out = 1'b0;
  assign sda_oe = s.oe;

  // Control fields
  assign diag_timing_normal = s.cb1[aic_pkg::CB1_DIAG_TIMING];
  assign diag_cycle_en = s.cb1[aic_pkg::CB1_DIAG_EN];
  assign offset_det_en = s.cb1[aic_pkg::CB1_OFFSET_EN];
  assign front_gain_low = s.cb1[aic_pkg::CB1_FRONT_GAIN];
  assign rear_gain_low = s.cb1[aic_pkg::CB1_REAR_GAIN];
  assign front_unmute = s.cb1[aic_pkg::CB1_FRONT_UNMUTE];
  assign rear_unmute = s.cb1[aic_pkg::CB1_REAR_UNMUTE];
  assign clip_thr_high = s.cb1[aic_pkg::CB1_CLIP_THR];
  assign cur_thr_low = s.cb2[aic_pkg::CB2_CUR_THR];
  assign fast_mute = s.cb2[aic_pkg::CB2_FAST_MUTE];
  assign clip_pin_offset = s.cb2[aic_pkg::CB2_CLIP_PIN];
  assign standby_off = s.cb2[aic_pkg::CB2_STBY_OFF];
  assign line_drv_diag = s.cb2[aic_pkg::CB2_LINE_DIAG];
  assign cur_det_en = s.cb2[aic_pkg::CB2_CUR_EN];
  assign front_low_iq = s.cb2[aic_pkg::CB2_FRONT_LOWIQ];
  assign rear_low_iq = s.cb2[aic_pkg::CB2_REAR_LOWIQ];

  // Checks
  addr_miss_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    evt_c && noss_c && s.state == aic_pkg::ST_ADDR && !match_c
    |=> s.state == aic_pkg::ST_IDLE && !sda_oe
  ) else $error("foreign address not dropped");
  dir_pick_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    fall_c && noss_c && s.state == aic_pkg::ST_ADDR && s.ack_pend
      && s.bcnt == aic_pkg::BIT_ACK
    |=> s.state == (s.rd ? aic_pkg::ST_READ : aic_pkg::ST_WRITE)
  ) else $error("direction not taken from address");
  ctrl_pair_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    evt_c && noss_c && s.state == aic_pkg::ST_WRITE && s.idx == 3'h1
    |=> s.cb1 == $past(s.stage) && s.cb2 == $past(lnk_byte)
  ) else $error("control pair not committed");
  first_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    evt_c && noss_c && s.state == aic_pkg::ST_WRITE && s.idx == 3'h0
    |=> $stable(s.cb1) && $stable(s.cb2)
  ) else $error("control changed on first byte");
  ack_low_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    fall_c && noss_c && s.bcnt == aic_pkg::BIT_LAST && s.ack_pend
      && s.state != aic_pkg::ST_READ
    |=> sda_oe ##1 sda_oe
  ) else $error("acknowledge not driven");
  read_bit_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    fall_c && noss_c && s.state == aic_pkg::ST_READ
      && s.bcnt < 4'h7 && s.idx < aic_pkg::N_STAT
    |=> sda_oe == !$past(bit_c)
  ) else $error("status bit driven wrong");
  done_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !s.cb1[aic_pkg::CB1_DIAG_EN] |-> !stat_c[0][aic_pkg::ST_LO]
  ) else $error("diag done shown while disabled");
  cur_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !s.cb2[aic_pkg::CB2_CUR_EN] |-> !stat_c[0][aic_pkg::ST_CUR]
      && !stat_c[3][aic_pkg::ST_CUR]
  ) else $error("current result shown while disabled");
  mirror_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(s.cb2[aic_pkg::CB2_STBY_OFF]) |-> stat_c[2][aic_pkg::ST_HI]
      && stat_c[2][aic_pkg::ST_LO] == s.cb1[aic_pkg::CB1_DIAG_EN]
  ) else $error("status three mirror wrong");
  once_only_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    evt_c && noss_c && s.state == aic_pkg::ST_ADDR && match_c
      && lnk_byte[0] && combo_c[0] && s.once[0]
    |=> s.tx[0][1:0] == 2'b00
  ) else $error("double short reported twice");
  fault_keep_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s.held[0][aic_pkg::FI_SLOAD] |-> stat_c[0][aic_pkg::ST_SLOAD]
  ) else $error("held fault not reported");
endmodule : aic_ctrl_port

/* dv/aic_host_model.sv */
`timescale 1ns/1ps
module aic_host_model (
  // Link
  output logic scl_clk,
  output logic sda_pull,
  input wire logic sda_in
);
  // Clock and data idle high between frames
  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
  end

  // One 48 ns clock: data moves 8 ns after the fall, sampled in the high phase
  task automatic pulse(input logic bit_v, output logic seen);
    scl_clk = 1'b0;
    #8;
    sda_pull = ~bit_v;
    #16;
    scl_clk = 1'b1;
    #12;
    seen = sda_in;
    #12;
  endtask : pulse

  task automatic start();
    sda_pull = 1'b1;
    #24;
  endtask : start

  task automatic stop();
    scl_clk = 1'b0;
    #8;
    sda_pull = 1'b1;
    #16;
    scl_clk = 1'b1;
    #24;
    sda_pull = 1'b0;
    #48;
  endtask : stop

  // Byte out MSB first, then ninth clock with the line released
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // Byte in MSB first; last byte answered with a release (no acknowledge)
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(last, s);
  endtask : rd_byte
endmodule : aic_host_model

/* dv/aic_ctrl_port_bench.sv */
`timescale 1ns/1ps
module aic_ctrl_port_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic thermal_warn = 1'b0;
  logic diag_done = 1'b0;
  logic [aic_pkg::NCH-1:0][aic_pkg::FLT_W-1:0] chan_flt = '0;
  logic scl_clk;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  wire logic sda_line;
  wire logic [7:0] cb1_seen;
  wire logic [7:0] cb2_seen;
  logic [7:0] cb1_exp = 8'h00;
  logic [7:0] cb2_exp = 8'h00;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  // Open-drain wire with pull-up
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

  aic_host_model host (
    .scl_clk(scl_clk),
    .sda_pull(sda_pull),
    .sda_in(sda_line)
  );

  aic_ctrl_port dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_clk(scl_clk),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .thermal_warn(thermal_warn),
    .diag_done(diag_done),
    .chan_flt(chan_flt),
    .diag_timing_normal(cb1_seen[7]),
    .diag_cycle_en(cb1_seen[6]),
    .offset_det_en(cb1_seen[5]),
    .front_gain_low(cb1_seen[4]),
    .rear_gain_low(cb1_seen[3]),
    .front_unmute(cb1_seen[2]),
    .rear_unmute(cb1_seen[1]),
    .clip_thr_high(cb1_seen[0]),
    .cur_thr_low(cb2_seen[7]),
    .fast_mute(cb2_seen[6]),
    .clip_pin_offset(cb2_seen[5]),
    .standby_off(cb2_seen[4]),
    .line_drv_diag(cb2_seen[3]),
    .cur_det_en(cb2_seen[2]),
    .front_low_iq(cb2_seen[1]),
    .rear_low_iq(cb2_seen[0])
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // Bits 5..0 of one channel's status byte
  function automatic logic [5:0] chan_exp(input logic [6:0] f);
    return {f[6] & cb2_exp[2], f[5], f[2], f[5] ? (f[4] & cb1_exp[5]) : f[3], f[1], f[0]};
  endfunction : chan_exp

  task automatic set_in(input logic t, input logic d, input logic [3:0][6:0] f);
    @(posedge sys_clk);
    thermal_warn <= t;
    diag_done <= d;
    chan_flt <= f;
    repeat (8) @(posedge sys_clk);
  endtask : set_in

  // Address, n data bytes, stop; then the control outputs
  task automatic host_write(input logic [7:0] a, input logic [7:0] b1, input logic [7:0] b2,
                            input int n);
    logic [7:0] d [3];
    logic ack;
    logic hit;
    d = '{b1, b2, 8'h3c};
    hit = (a[7:1] === aic_pkg::DEV_ADDR);
    host.start();
    host.wr_byte(a, ack);
    check({7'h00, ack}, {7'h00, hit});
    for (int i = 0; hit && i < n; i++) begin
      host.wr_byte(d[i], ack);
      check({7'h00, ack}, {7'h00, i < 2});
    end
    host.stop();
    if (hit && n >= 2) begin
      cb1_exp = b1;
      cb2_exp = b2;
    end
    check(cb1_seen, cb1_exp);
    check(cb2_seen, cb2_exp);
  endtask : host_write

  // Read n status bytes; ch1_sh gives the expected channel one short bits
  task automatic host_read(input int n, input logic [1:0] ch1_sh);
    logic ack;
    logic [7:0] b;
    logic [7:0] e [5];
    e[0] = {thermal_warn, diag_done & cb1_exp[6], chan_exp(chan_flt[0])};
    e[0][1:0] = ch1_sh;
    e[1] = {cb1_exp[5], cb2_exp[2], chan_exp(chan_flt[1])};
    e[2] = {cb2_exp[4], cb1_exp[6], chan_exp(chan_flt[2])};
    e[3] = {2'b00, chan_exp(chan_flt[3])};
    e[4] = 8'hff;
    host.start();
    host.wr_byte(8'hd9, ack);
    check({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      host.rd_byte(i == n - 1, b);
      check(b, e[i]);
    end
    host.stop();
  endtask : host_read

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      results();
    end
  end

  logic [7:0] p1 [4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};
  logic [7:0] p2 [4] = '{8'hff, 8'h00, 8'h5a, 8'ha5};

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(cb1_seen, 8'h00);
    check(cb2_seen, 8'h00);
    repeat (10) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      host_write(8'hd8, p1[k], p2[k], 2);
    end
    $display("test control_write done");
    host_write(8'hda, 8'h00, 8'h00, 2);
    host_write(8'h58, 8'h00, 8'h00, 2);
    $display("test wrong_address done");
    host_write(8'hd8, 8'h12, 8'h00, 1);
    host_write(8'hd8, 8'he0, 8'h14, 3);
    $display("test partial_and_extra_bytes done");
    set_in(1'b1, 1'b1, {7'h50, 7'h1f, 7'h06, 7'h49});
    host_read(5, 2'b01);
    set_in(1'b0, 1'b0, '0);
    host_read(4, 2'b00);
    $display("test status_read done");
    set_in(1'b0, 1'b1, {7'h00, 7'h00, 7'h00, 7'h21});
    host_read(4, 2'b01);
    set_in(1'b0, 1'b1, {7'h00, 7'h00, 7'h00, 7'h20});
    host_read(4, 2'b01);
    host_read(4, 2'b00);
    $display("test removed_fault done");
    set_in(1'b0, 1'b1, {7'h00, 7'h00, 7'h00, 7'h38});
    host_read(4, 2'b00);
    host_write(8'hd8, 8'hc0, 8'h14, 2);
    host_read(4, 2'b00);
    $display("test permanent_offset done");
    set_in(1'b0, 1'b1, {7'h00, 7'h00, 7'h00, 7'h23});
    host_read(4, 2'b11);
    host_read(4, 2'b00);
    $display("test ground_supply_short done");
    results();
  end
endmodule : aic_ctrl_port_bench
